/* File: core/smc_consts.vh */
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
// register word offsets (byte addresses)
`define SMC_OFF_PCC      4'h0
`define SMC_OFF_ITMODE   4'h4
`define SMC_OFF_IRQ      4'h8
`define SMC_OFF_STATUS   4'hc
// processor clock control fields
`define SMC_PCC_STOP_BIT 3
`define SMC_PCC_HALT_BIT 2
`define SMC_PCC_RESET    4'h0
// interval timer mode codes
`define SMC_ITM_RESET    3'h0
`define SMC_ITM_W20      3'h0
`define SMC_ITM_W17      3'h3
`define SMC_ITM_W15      3'h5
`define SMC_ITM_W13      3'h7
// settling waits in main clock periods
`define SMC_WAIT_20      32'h00100000
`define SMC_WAIT_17      32'h00020000
`define SMC_WAIT_15      32'h00008000
`define SMC_WAIT_13      32'h00002000
// reset settling wait 31.3 ms = 2^17 periods of a 4.19 MHz main clock
`define SMC_WAIT_RESET   32'h00020000
// irq source positions: a,b,c,e,interval timer,watch timer
`define SMC_IRQ_EXT_A    0
`define SMC_IRQ_EXT_C    2
`define SMC_IRQ_WATCH    5
`define SMC_NIRQ         6
`endif

/* File: core/smc_wait_counter.v */
`timescale 1ns/1ps
// settling countdown; done pulses one cycle after count reaches one (count never reaches zero)
module smc_wait_counter #(
  parameter W = 32
) (
  input  wire         i_ref_clk,
  input  wire         i_rst_n,
  input  wire         i_load,
  input  wire [W-1:0] i_count,
  output reg          o_busy,
  output reg          o_done
);
  reg [W-1:0] cnt_reg;
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= {W{1'b0}};
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        cnt_reg <= i_count;
        o_busy  <= 1'b1;
      end else if (o_busy) begin
        if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // smc_wait_counter

/* File: core/smc_standby_ctrl.v */
// Operation
// - stop sets bit3, halt sets bit2
// - stop only from main clock, halt either
// - stop halts main oscillator and cpu
// - halt gates only cpu clock
// - interval timer stops in stop mode
// - serial a: stop needs ext clock
// - serial b: stop ext, halt main
// - event counter: stop needs pin clock
// - watch timer stop only on subclock
// - adc and pulse timer stop in stop
// - ext irq a disabled in standby
// - reset or enabled irq releases standby
// - state retained throughout standby
// - stop ties crystal input to ground unless ext clock used
// - pending enabled irq releases immediately
// - stop with pending irq halts, waits
// - reset leaves stop after settle wait
// - irq stop release wait from mode bits
// - master enable clear: resume, flag kept
// - master enable set: vector, except watch/c
`timescale 1ns/1ps
`include "smc_consts.vh"
module smc_standby_ctrl #(
  parameter [31:0] WAIT_RESET = `SMC_WAIT_RESET,
  parameter [31:0] WAIT_20    = `SMC_WAIT_20,
  parameter [31:0] WAIT_17    = `SMC_WAIT_17,
  parameter [31:0] WAIT_15    = `SMC_WAIT_15,
  parameter [31:0] WAIT_13    = `SMC_WAIT_13
) (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  input  wire        i_cpu_on_subclock,
  input  wire        i_ext_clock_used,
  input  wire        i_serial_a_ext_clk_sel,
  input  wire        i_serial_b_ext_clk_sel,
  input  wire        i_event_pin_clk_sel,
  input  wire        i_watch_on_subclock,
  input  wire [5:0]  i_irq_event,
  output reg         o_main_osc_en,
  output reg         o_cpu_clk_en,
  output reg         o_crystal_input_gnd,
  output reg         o_interval_timer_run,
  output reg         o_serial_a_run,
  output reg         o_serial_b_run,
  output reg         o_event_counter_run,
  output reg         o_watch_timer_run,
  output reg         o_adc_run,
  output reg         o_pulse_timer_run,
  output reg         o_ext_irq_a_en,
  output reg         o_vector_request,
  output reg  [2:0]  o_mode
);
  // ****************************************
  // reset synchroniser
  // ****************************************
  reg rst_s1_reg;
  reg rst_reg;
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_reg    <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_reg    <= rst_s1_reg;
    end
  end
  wire rst_n = rst_reg;

  // ****************************************
  // state encoding
  // ****************************************
  localparam [2:0] ST_RUN    = 3'h0;
  localparam [2:0] ST_HALT   = 3'h1;
  localparam [2:0] ST_STOP   = 3'h2;
  localparam [2:0] ST_SETTLE = 3'h3;
  localparam [2:0] ST_BOOT   = 3'h4;

  // ****************************************
  // registers
  // ****************************************
  reg [3:0] pcc_reg;
  reg [2:0] itmode_reg;
  reg [5:0] irq_flag_reg;
  reg [5:0] irq_en_reg;
  reg       ime_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] vec_instr_reg;
  reg       load;
  reg [31:0] load_val;
  wire      wait_busy;
  wire      wait_done;

  wire acc        = i_avs_read | i_avs_write;
  wire wr_pcc     = i_avs_write && !o_avs_waitrequest && i_avs_address == `SMC_OFF_PCC;
  wire wr_itm     = i_avs_write && !o_avs_waitrequest && i_avs_address == `SMC_OFF_ITMODE;
  wire wr_irq     = i_avs_write && !o_avs_waitrequest && i_avs_address == `SMC_OFF_IRQ;
  wire [5:0] pend = irq_flag_reg & irq_en_reg;
  // ext irq a is masked as a release source while in standby
  wire [5:0] stby_mask = 6'h3e;
  wire release_irq = |(pend & stby_mask);
  // watch timer and ext c release never vector
  wire novec = pend[`SMC_IRQ_WATCH] | pend[`SMC_IRQ_EXT_C];

  // settling wait chosen by interval timer mode
  always @* begin
    case (itmode_reg)
      `SMC_ITM_W17: load_val = WAIT_17;
      `SMC_ITM_W15: load_val = WAIT_15;
      `SMC_ITM_W13: load_val = WAIT_13;
      default:      load_val = WAIT_20;
    endcase
  end

  // ****************************************
  // standby state machine
  // ****************************************
  always @* begin
    state_next = state_reg;
    load       = 1'b0;
    case (state_reg)
      ST_BOOT: begin
        if (wait_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pcc_reg[`SMC_PCC_STOP_BIT] && !i_cpu_on_subclock) begin
          if (release_irq) begin
            state_next = ST_SETTLE;
            load       = 1'b1;
          end else begin
            state_next = ST_STOP;
          end
        end else if (pcc_reg[`SMC_PCC_HALT_BIT]) begin
          state_next = ST_HALT;
        end
      end
      ST_HALT: begin
        if (release_irq) begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        if (release_irq) begin
          state_next = ST_SETTLE;
          load       = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (wait_done) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  // boot wait loads on the first cycle after reset release
  reg boot_load_reg;

  smc_wait_counter #(
    .W(32)
  ) u_wait (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_load    (load | boot_load_reg),
    .i_count   (boot_load_reg ? WAIT_RESET : load_val),
    .o_busy    (wait_busy),
    .o_done    (wait_done)
  );

  wire leaving = (state_reg != ST_RUN) && (state_next == ST_RUN) && (state_reg != ST_BOOT);

  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_BOOT;
      boot_load_reg <= 1'b1;
      pcc_reg       <= `SMC_PCC_RESET;
      itmode_reg    <= `SMC_ITM_RESET;
      irq_flag_reg  <= 6'h00;
      irq_en_reg    <= 6'h00;
      ime_reg       <= 1'b0;
      vec_instr_reg <= 2'h0;
      o_vector_request <= 1'b0;
    end else begin
      boot_load_reg <= 1'b0;
      state_reg     <= state_next;
      // stop and halt bits cleared on release; other register contents untouched by standby transitions
      if (leaving) begin
        pcc_reg[3:2] <= 2'b00;
      end else if (wr_pcc) begin
        pcc_reg <= i_avs_writedata[3:0];
      end
      if (wr_itm) begin
        itmode_reg <= i_avs_writedata[2:0];
      end
      if (wr_irq) begin
        irq_en_reg <= i_avs_writedata[13:8];
        ime_reg    <= i_avs_writedata[16];
      end
      // hardware set wins over software clear; flags kept on release
      irq_flag_reg <= (irq_flag_reg & ~(wr_irq ? i_avs_writedata[5:0] : 6'h00)) | i_irq_event;
      // two instructions after release, then vector
      o_vector_request <= 1'b0;
      if (leaving && ime_reg && !novec) begin
        vec_instr_reg <= 2'h2;
      end else if (vec_instr_reg != 2'h0) begin
        vec_instr_reg <= vec_instr_reg - 2'h1;
        if (vec_instr_reg == 2'h1) begin
          o_vector_request <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // clock and peripheral gating
  // ****************************************
  wire in_stop   = (state_next == ST_STOP);
  wire in_halt   = (state_next == ST_HALT) || (state_next == ST_SETTLE);
  wire main_runs = !in_stop && !i_cpu_on_subclock;
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_main_osc_en        <= 1'b1;
      o_cpu_clk_en         <= 1'b0;
      o_crystal_input_gnd  <= 1'b0;
      o_interval_timer_run <= 1'b1;
      o_serial_a_run       <= 1'b0;
      o_serial_b_run       <= 1'b0;
      o_event_counter_run  <= 1'b0;
      o_watch_timer_run    <= 1'b0;
      o_adc_run            <= 1'b0;
      o_pulse_timer_run    <= 1'b0;
      o_ext_irq_a_en       <= 1'b1;
      o_mode               <= ST_BOOT;
    end else begin
      o_mode               <= state_next;
      o_main_osc_en        <= !in_stop;
      o_cpu_clk_en         <= !in_stop && !in_halt && state_next != ST_BOOT;
      o_crystal_input_gnd  <= in_stop && !i_ext_clock_used;
      o_interval_timer_run <= !in_stop;
      o_serial_a_run       <= in_stop ? i_serial_a_ext_clk_sel : (main_runs | i_serial_a_ext_clk_sel);
      o_serial_b_run       <= in_stop ? i_serial_b_ext_clk_sel : main_runs;
      o_event_counter_run  <= in_stop ? i_event_pin_clk_sel : main_runs;
      o_watch_timer_run    <= in_stop ? i_watch_on_subclock : 1'b1;
      o_adc_run            <= main_runs;
      o_pulse_timer_run    <= main_runs;
      o_ext_irq_a_en       <= !(in_stop || in_halt);
    end
  end

  // ****************************************
  // avalon slave: one wait cycle per access
  // ****************************************
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= !(acc && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        if (i_avs_address == `SMC_OFF_PCC) begin
          o_avs_readdata <= {28'h0000000, pcc_reg};
        end else if (i_avs_address == `SMC_OFF_ITMODE) begin
          o_avs_readdata <= {29'h00000000, itmode_reg};
        end else if (i_avs_address == `SMC_OFF_IRQ) begin
          o_avs_readdata <= {15'h0000, ime_reg, 2'h0, irq_en_reg, 2'h0, irq_flag_reg};
        end else if (i_avs_address == `SMC_OFF_STATUS) begin
          o_avs_readdata <= {28'h0000000, wait_busy, state_reg};
        end else begin
          o_avs_readdata <= 32'h00000000;
        end
      end
    end
  end
endmodule // smc_standby_ctrl

/* File: dv/smc_standby_ctrl_assertions.sv */
`timescale 1ns/1ps
module smc_standby_ctrl_assertions #(
  parameter [31:0] WAIT_20 = 32'h00000028
) (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       i_ext_clock_used,
  input wire logic       i_serial_b_ext_clk_sel,
  input wire logic       i_watch_on_subclock,
  input wire logic [2:0] o_mode,
  input wire logic       o_main_osc_en,
  input wire logic       o_cpu_clk_en,
  input wire logic       o_crystal_input_gnd,
  input wire logic       o_interval_timer_run,
  input wire logic       o_serial_b_run,
  input wire logic       o_watch_timer_run,
  input wire logic       o_adc_run,
  input wire logic       o_pulse_timer_run,
  input wire logic       o_ext_irq_a_en,
  input wire logic       o_vector_request
);
  // ****
  // sequences and helpers
  // ****
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_stop; (o_mode == 3'h2)[*2]; endsequence
  sequence s_halt; (o_mode == 3'h1)[*2]; endsequence
  // settle length counted here, too long for a delay range
  logic [31:0] settle_cnt;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) settle_cnt <= 32'h0;
    else settle_cnt <= (o_mode == 3'h3) ? settle_cnt + 32'h1 : 32'h0;
  end
  // ****
  // properties
  // ****
  AST_STOP_CLK: assert property (s_stop |-> !o_main_osc_en && !o_cpu_clk_en)
    else $error("stop mode clocks wrong");
  AST_STOP_GND: assert property (s_stop |-> o_crystal_input_gnd == !i_ext_clock_used)
    else $error("crystal input grounding wrong");
  AST_HALT_CLK: assert property (s_halt |-> o_main_osc_en && !o_cpu_clk_en && o_interval_timer_run)
    else $error("halt mode clocks wrong");
  AST_STOP_PERIPH: assert property (s_stop |-> !(o_interval_timer_run || o_adc_run || o_pulse_timer_run))
    else $error("peripheral runs in stop");
  AST_STOP_SRC: assert property (s_stop |->
    o_watch_timer_run == i_watch_on_subclock && o_serial_b_run == i_serial_b_ext_clk_sel)
    else $error("stop source gating wrong");
  AST_EXT_A: assert property ((s_stop or s_halt) |-> !o_ext_irq_a_en)
    else $error("ext irq a enabled in standby");
  AST_SETTLE_BOUND: assert property (settle_cnt <= WAIT_20 + 32'h4)
    else $error("settle wait too long");
  AST_VEC_PULSE: assert property (o_vector_request |=> !o_vector_request)
    else $error("vector request not a pulse");
endmodule // smc_standby_ctrl_assertions

bind smc_standby_ctrl smc_standby_ctrl_assertions #(.WAIT_20(WAIT_20)) u_chk (.i_ref_clk, .i_rst_n,
  .i_ext_clock_used, .i_serial_b_ext_clk_sel, .i_watch_on_subclock, .o_mode, .o_main_osc_en, .o_cpu_clk_en,
  .o_crystal_input_gnd, .o_interval_timer_run, .o_serial_b_run, .o_watch_timer_run, .o_adc_run,
  .o_pulse_timer_run, .o_ext_irq_a_en, .o_vector_request);

/* File: dv/smc_standby_ctrl_test.sv */
`timescale 1ns/1ps
module smc_standby_ctrl_test;
  // ****
  // stimulus and design
  // ****
  logic i_ref_clk = 0, i_rst_n = 0, i_avs_read = 0, i_avs_write = 0, i_cpu_on_subclock = 0;
  logic i_ext_clock_used = 0, i_serial_a_ext_clk_sel = 0, i_serial_b_ext_clk_sel = 1;
  logic i_event_pin_clk_sel = 0, i_watch_on_subclock = 1;
  logic [3:0] i_avs_address = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic [5:0] i_irq_event = 6'h0;
  logic [2:0] o_mode;
  logic o_avs_waitrequest, o_main_osc_en, o_cpu_clk_en, o_crystal_input_gnd, o_interval_timer_run;
  logic o_serial_a_run, o_serial_b_run, o_event_counter_run, o_watch_timer_run, o_adc_run;
  logic o_pulse_timer_run, o_ext_irq_a_en, o_vector_request;
  int miscompares = 0, num_checks = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  // short waits keep the run small
  smc_standby_ctrl #(.WAIT_RESET(20), .WAIT_20(40), .WAIT_17(16), .WAIT_15(8), .WAIT_13(4)) DUT (
    .i_ref_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
    .o_avs_waitrequest, .i_cpu_on_subclock, .i_ext_clock_used, .i_serial_a_ext_clk_sel,
    .i_serial_b_ext_clk_sel, .i_event_pin_clk_sel, .i_watch_on_subclock, .i_irq_event, .o_main_osc_en,
    .o_cpu_clk_en, .o_crystal_input_gnd, .o_interval_timer_run, .o_serial_a_run, .o_serial_b_run,
    .o_event_counter_run, .o_watch_timer_run, .o_adc_run, .o_pulse_timer_run, .o_ext_irq_a_en,
    .o_vector_request, .o_mode);
  // ****
  // shared tasks
  // ****
  task report_and_stop;
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 20) begin miscompares++; report_and_stop; end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task wait_mode(input logic [2:0] m, output int n);
    n = 0;
    while (o_mode !== m && n < 2000) begin @(posedge i_ref_clk); n++; end
    if (n >= 2000) begin miscompares++; report_and_stop; end
  endtask
  task irq(input logic [5:0] b);
    @(posedge i_ref_clk) i_irq_event <= b;
    @(posedge i_ref_clk) i_irq_event <= 6'h0;
  endtask
  // ****
  // scenarios
  // ****
  task boot;
    int n;
    i_rst_n <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    wait_mode(3'h0, n);
    chk("boot_wait", 32'h1, n >= 20 && n <= 30);
  endtask
  task t_regs;
    logic [31:0] q;
    bus(1'b0, 4'h0, 32'h0, q); chk("pcc_reset", 32'h0, q);
    bus(1'b0, 4'h4, 32'h0, q); chk("itm_reset", 32'h0, q);
    wr(4'h0, 32'h3); bus(1'b0, 4'h0, 32'h0, q); chk("pcc_sel", 32'h3, q);
    wr(4'h0, 32'h0); wr(4'h2, 32'hf);
    bus(1'b0, 4'h2, 32'h0, q); chk("unmapped", 32'h0, q);
    bus(1'b0, 4'h0, 32'h0, q); chk("pcc_kept", 32'h0, q);
  endtask
  task t_halt(input logic [31:0] cfg, input logic [5:0] src, input logic expv);
    int n;
    logic [31:0] q;
    logic v;
    wr(4'h8, cfg); wr(4'h0, 32'h4);
    wait_mode(3'h1, n);
    repeat (2) @(posedge i_ref_clk);
    chk("halt_cpu", 32'h0, o_cpu_clk_en);
    chk("halt_osc", 32'h1, o_main_osc_en);
    chk("halt_it", 32'h1, o_interval_timer_run);
    chk("halt_ser_a", 32'h1, o_serial_a_run);
    chk("halt_ser_b", 32'h1, o_serial_b_run);
    chk("halt_evt", 32'h1, o_event_counter_run);
    chk("halt_watch", 32'h1, o_watch_timer_run);
    chk("halt_adc", 32'h1, o_adc_run);
    chk("halt_pulse", 32'h1, o_pulse_timer_run);
    chk("halt_exta_en", 32'h0, o_ext_irq_a_en);
    irq(6'h1); repeat (3) @(posedge i_ref_clk);
    chk("exta_ignored", 32'h1, o_mode);
    irq(src); wait_mode(3'h0, n);
    v = 1'b0;
    repeat (6) begin @(posedge i_ref_clk); v = v | o_vector_request; end
    chk("vector", expv, v);
    bus(1'b0, 4'h0, 32'h0, q); chk("pcc_clr", 32'h0, q);
    bus(1'b0, 4'h8, 32'h0, q); chk("flag_kept", src, q[5:0] & src);
  endtask
  task t_stop(input logic [2:0] code, input int w);
    int n;
    wr(4'h4, {29'h0, code}); wr(4'h8, 32'h23f); wr(4'h0, 32'h8);
    wait_mode(3'h2, n);
    repeat (2) @(posedge i_ref_clk);
    chk("stop_osc", 32'h0, o_main_osc_en);
    chk("stop_gnd", 32'h1, o_crystal_input_gnd);
    chk("stop_cpu", 32'h0, o_cpu_clk_en);
    chk("stop_it", 32'h0, o_interval_timer_run);
    chk("stop_ser_a", 32'h0, o_serial_a_run);
    chk("stop_ser_b", 32'h1, o_serial_b_run);
    chk("stop_evt", 32'h0, o_event_counter_run);
    chk("stop_watch", 32'h1, o_watch_timer_run);
    chk("stop_adc", 32'h0, o_adc_run);
    chk("stop_pulse", 32'h0, o_pulse_timer_run);
    chk("stop_exta_en", 32'h0, o_ext_irq_a_en);
    irq(6'h2); wait_mode(3'h3, n); wait_mode(3'h0, n);
    chk("settle", 32'h1, n >= w - 1 && n <= w + 4);
  endtask
  task t_sub;
    int n;
    wr(4'h8, 32'h23f);
    i_cpu_on_subclock <= 1'b1;
    wr(4'h0, 32'h8); repeat (4) @(posedge i_ref_clk);
    chk("sub_stop", 32'h0, o_mode);
    wr(4'h0, 32'hc); wait_mode(3'h1, n);
    irq(6'h2); wait_mode(3'h0, n);
    i_cpu_on_subclock <= 1'b0;
  endtask
  task t_pend;
    int n;
    wr(4'h8, 32'h23f); irq(6'h2); wr(4'h0, 32'h8);
    wait_mode(3'h3, n);
    chk("pend_settle", 32'h1, n < 8);
    wait_mode(3'h0, n);
  endtask
  initial begin
    int n;
    boot;
    t_regs;
    t_halt(32'h33f, 6'h2, 1'b0);
    t_halt(32'h1033f, 6'h2, 1'b1);
    t_halt(32'h1233f, 6'h20, 1'b0);
    t_stop(3'h3, 16);
    t_stop(3'h5, 8);
    t_stop(3'h7, 4);
    t_stop(3'h0, 40);
    t_sub;
    t_pend;
    i_ext_clock_used <= 1'b1;
    wr(4'h8, 32'h23f); wr(4'h0, 32'h8); wait_mode(3'h2, n);
    repeat (2) @(posedge i_ref_clk);
    chk("ext_clk_gnd", 32'h0, o_crystal_input_gnd);
    boot;
    report_and_stop;
  end
endmodule // smc_standby_ctrl_test
